/* File: inc/cic_defs.svh */
// Purpose: Offsets, field positions, reset values and counts of the interrupt control block
// Assumes: Wishbone byte addresses, one 8-bit register per aligned word
// Notes:   Included by its bare name
`ifndef CIC_DEFS_SVH
`define CIC_DEFS_SVH
`define CIC_ADR_W           6
`define CIC_OFF_CTRL        6'h00
`define CIC_OFF_TMR_FLAGS   6'h04
`define CIC_OFF_CCP_FLAGS   6'h08
`define CIC_OFF_TMR_EN      6'h0C
`define CIC_OFF_CCP_EN      6'h10
`define CIC_OFF_IRQ_STAT    6'h14
`define CIC_OFF_IRQ_MASK    6'h18
`define CIC_OFF_STATE       6'h1C
`define CIC_BIT_GIE         7
`define CIC_BIT_PERIPHERAL_INTERRUPT_ENABLE        6
`define CIC_FLAG_MASK       8'h03
`define CIC_RST_BYTE        8'h00
`define CIC_VECTOR          13'h0004
`define CIC_QPHASES         2'h3
`define CIC_ST_TAKEN        0
`define CIC_ST_RETURN       1
`define CIC_ST_FLAG         2
`endif

/* File: inc/cic_pkg.sv */
// Purpose: Types of the interrupt control block
// Assumes: Nothing
// Notes:   Constants live in cic_defs.svh
package cic_pkg;
  typedef enum logic [1:0] {
    CIC_MODE_CAPTURE = 2'h0,
    CIC_MODE_COMPARE = 2'h1,
    CIC_MODE_PWM     = 2'h2,
    CIC_MODE_OFF     = 2'h3
  } cic_mode_t;
endpackage : cic_pkg

/* File: hdl/cic_core_int.sv */
// Purpose: Interrupt flag, enable and vectoring control for an 8-bit core
// Assumes: Single 25 MHz clock, sync active-high reset, classic Wishbone slave
// Notes:   Rules of operation follow, one tag per line
// Operation
// - Any reset leaves global interrupt enable clear.
// - Redirect needs global, source and, for peripheral sources, peripheral enable.
// - Flags set on events regardless of any enable bit.
// - Taking an interrupt flushes, clears global enable, pushes pc, shadows, vectors 0004h.
// - During service, events set flags but do not redirect.
// - Return pops address, restores shadows, sets global enable.
// - Global enable clear ignores interrupts; pending ones served later.
// - Requests sampled in the first quarter phase.
// - Latency depends on the instruction executing at detection.
// - Timer flag bit 1 on postscaler overflow or 1:1 period match.
// - Timer flag bit 0 on timer_a overflow, held until cleared.
// - Flag bits 7..2 unimplemented, read zero.
// - Capture flag bit 1 from unit b per mode, software cleared.
// - Capture flag bit 0 from unit a per mode, software cleared.
// - Flag bits readable, writable, hardware settable, reset zero.
// - Two peripheral request flag registers exist.
`timescale 1ns/1ns
`include "cic_defs.svh"
module cic_core_int #(
  parameter int PC_W = 13
) (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic [5:0]      wb_adr_i,
  input  wire logic [31:0]     wb_dat_i,
  output logic      [31:0]     wb_dat_o,
  input  wire logic            wb_we_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  output logic                 wb_ack_o,
  input  wire logic            tmr_a_ovf_i,
  input  wire logic            tmr_b_postscale_ovf_i,
  input  wire logic            tmr_b_match_i,
  input  wire logic            tmr_b_one_to_one_i,
  input  wire cic_pkg::cic_mode_t cap_a_mode_i,
  input  wire logic            cap_a_capture_i,
  input  wire logic            cap_a_compare_i,
  input  wire logic            cap_a_trail_i,
  input  wire cic_pkg::cic_mode_t cap_b_mode_i,
  input  wire logic            cap_b_capture_i,
  input  wire logic            cap_b_compare_i,
  input  wire logic            cap_b_trail_i,
  input  wire logic [4:0]      other_flags_i,
  input  wire logic [4:0]      other_en_i,
  input  wire logic [PC_W-1:0] pc_i,
  input  wire logic [7:0]      ctx_i,
  input  wire logic            instr_done_i,
  input  wire logic            retfi_i,
  input  wire logic [PC_W-1:0] stack_top_i,
  output logic                 flush_o,
  output logic                 push_o,
  output logic                 pop_o,
  output logic [PC_W-1:0]      push_pc_o,
  output logic                 pc_load_o,
  output logic [PC_W-1:0]      pc_new_o,
  output logic                 ctx_restore_o,
  output logic [7:0]           ctx_o,
  output logic                 in_service_o,
  output logic                 irq_o
);

  // Elaboration check: the vector and return address need 13 to 16 bits
  if (PC_W < 13 || PC_W > 16) begin : g_bad_pc_w
    $error("PC_W must be 13..16");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Quarter-phase counter and request sampling
  logic [1:0] qph_r;
  logic       gie_r;
  logic       peripheral_interrupt_enable_r;
  logic [7:0] tmr_flags_r;
  logic [7:0] ccp_flags_r;
  logic [7:0] tmr_en_r;
  logic [7:0] ccp_en_r;
  logic [7:0] irq_stat_r;
  logic [7:0] irq_mask_r;
  logic       in_svc_r;
  logic       req_smp_r;
  logic       req_now;

  // Four clocks make one instruction cycle; phase 0 is the first quarter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      qph_r <= 2'h0;
    end else begin
      qph_r <= qph_r + 2'h1;
    end
  end

  // Combined request: other flags are core sources, ours are peripheral gated
  always_comb begin
    req_now = gie_r & ((|(other_flags_i & other_en_i)) |
              (peripheral_interrupt_enable_r & (|(tmr_flags_r & tmr_en_r) | |(ccp_flags_r & ccp_en_r))));
  end

  // Request latched only in the first quarter; a late event waits a cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_smp_r <= 1'b0;
    end else if (qph_r == 2'h0) begin
      req_smp_r <= req_now;
    end else if (!gie_r) begin
      req_smp_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: single-cycle ack, dropped the cycle after
  logic wb_hit;
  logic wr_stb;
  logic rd_stb;
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_stb = wb_hit & wb_we_i & wb_sel_i[0];
  assign rd_stb = wb_hit & ~wb_we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit;
    end
  end

  // Read mux; unmapped words read zero but still ack
  // A stray address never stalls the master, at the cost of no error reply
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_stb) begin
      unique case (wb_adr_i)
        `CIC_OFF_CTRL:      wb_dat_o <= {24'h0, gie_r, peripheral_interrupt_enable_r, 6'h0};
        `CIC_OFF_TMR_FLAGS: wb_dat_o <= {24'h0, tmr_flags_r};
        `CIC_OFF_CCP_FLAGS: wb_dat_o <= {24'h0, ccp_flags_r};
        `CIC_OFF_TMR_EN:    wb_dat_o <= {24'h0, tmr_en_r};
        `CIC_OFF_CCP_EN:    wb_dat_o <= {24'h0, ccp_en_r};
        `CIC_OFF_IRQ_STAT:  wb_dat_o <= {24'h0, irq_stat_r};
        `CIC_OFF_IRQ_MASK:  wb_dat_o <= {24'h0, irq_mask_r};
        `CIC_OFF_STATE:     wb_dat_o <= {24'h0, 6'h0, req_smp_r, in_svc_r};
        default:            wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Vectoring: take when sampled request meets an instruction boundary
  logic take;
  assign take = req_smp_r & gie_r & instr_done_i & ~retfi_i;

  // Global and peripheral enables; return sets and taking clears the global one only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gie_r  <= 1'b0;
      peripheral_interrupt_enable_r <= 1'b0;
    end else if (take) begin
      gie_r  <= 1'b0;
    end else if (retfi_i) begin
      gie_r  <= 1'b1;
    end else if (wr_stb && wb_adr_i == `CIC_OFF_CTRL) begin
      gie_r  <= wb_dat_i[`CIC_BIT_GIE];
      peripheral_interrupt_enable_r <= wb_dat_i[`CIC_BIT_PERIPHERAL_INTERRUPT_ENABLE];
    end
  end

  // Shadow context and service state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_svc_r <= 1'b0;
      ctx_o    <= 8'h00;
    end else if (take) begin
      in_svc_r <= 1'b1;
      ctx_o    <= ctx_i;
    end else if (retfi_i) begin
      in_svc_r <= 1'b0;
    end
  end

  // Core steering pulses; pop and restore ride on the return strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flush_o       <= 1'b0;
      push_o        <= 1'b0;
      pop_o         <= 1'b0;
      push_pc_o     <= '0;
      pc_load_o     <= 1'b0;
      pc_new_o      <= '0;
      ctx_restore_o <= 1'b0;
    end else begin
      flush_o       <= take;
      push_o        <= take;
      pop_o         <= retfi_i;
      ctx_restore_o <= retfi_i;
      pc_load_o     <= take | retfi_i;
      if (take) begin
        push_pc_o <= pc_i;
        pc_new_o  <= PC_W'(`CIC_VECTOR);
      end else if (retfi_i) begin
        pc_new_o  <= stack_top_i;
      end
    end
  end
  assign in_service_o = in_svc_r;

  //////////////////////////////////////////////////////////////////////////////
  // Flag event decode: set wins over a software clear in the same cycle
  logic [1:0] tmr_set;
  logic [1:0] ccp_set;
  assign tmr_set[0] = tmr_a_ovf_i;
  assign tmr_set[1] = tmr_b_postscale_ovf_i | (tmr_b_one_to_one_i & tmr_b_match_i);

  // One decoder per capture unit, chosen by its mode
  function automatic logic cap_evt(input cic_pkg::cic_mode_t m, input logic c,
                                   input logic p, input logic t);
    unique case (m)
      cic_pkg::CIC_MODE_CAPTURE: cap_evt = c;
      cic_pkg::CIC_MODE_COMPARE: cap_evt = p;
      cic_pkg::CIC_MODE_PWM:     cap_evt = t;
      cic_pkg::CIC_MODE_OFF:     cap_evt = 1'b0;
    endcase
  endfunction : cap_evt
  assign ccp_set[0] = cap_evt(cap_a_mode_i, cap_a_capture_i, cap_a_compare_i, cap_a_trail_i);
  assign ccp_set[1] = cap_evt(cap_b_mode_i, cap_b_capture_i, cap_b_compare_i, cap_b_trail_i);

  // Flags: software write, hardware set on top, upper bits held at zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr_flags_r <= `CIC_RST_BYTE;
      ccp_flags_r <= `CIC_RST_BYTE;
    end else begin
      tmr_flags_r <= ((wr_stb && wb_adr_i == `CIC_OFF_TMR_FLAGS) ? wb_dat_i[7:0] : tmr_flags_r)
                     & `CIC_FLAG_MASK | {6'h0, tmr_set};
      ccp_flags_r <= ((wr_stb && wb_adr_i == `CIC_OFF_CCP_FLAGS) ? wb_dat_i[7:0] : ccp_flags_r)
                     & `CIC_FLAG_MASK | {6'h0, ccp_set};
    end
  end

  // Individual enables of the two flag registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr_en_r <= `CIC_RST_BYTE;
      ccp_en_r <= `CIC_RST_BYTE;
    end else if (wr_stb && wb_adr_i == `CIC_OFF_TMR_EN) begin
      tmr_en_r <= wb_dat_i[7:0] & `CIC_FLAG_MASK;
    end else if (wr_stb && wb_adr_i == `CIC_OFF_CCP_EN) begin
      ccp_en_r <= wb_dat_i[7:0] & `CIC_FLAG_MASK;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // System interrupt: sticky, cleared by reading, a same-cycle event survives
  logic [7:0] stat_set;
  assign stat_set = {5'h0, |{tmr_set, ccp_set}, retfi_i, take};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= 8'h00;
      irq_mask_r <= 8'h00;
    end else begin
      irq_stat_r <= ((rd_stb && wb_adr_i == `CIC_OFF_IRQ_STAT) ? 8'h00 : irq_stat_r) | stat_set;
      if (wr_stb && wb_adr_i == `CIC_OFF_IRQ_MASK) begin
        irq_mask_r <= wb_dat_i[7:0];
      end
    end
  end
  assign irq_o = |(irq_stat_r & irq_mask_r);

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_take;
    take;
  endsequence
  sequence s_vectored;
    pc_load_o && pc_new_o == PC_W'(`CIC_VECTOR) && push_o && flush_o;
  endsequence

  AST_RESET_GIE: assert property (@(posedge clk_i) rst_i |=> !gie_r)
    else $error("global enable set after reset");
  AST_TAKE_VECTOR: assert property (@(posedge clk_i) disable iff (rst_i)
    s_take |=> s_vectored)
    else $error("take did not vector");
  AST_TAKE_CLEARS_GIE: assert property (@(posedge clk_i) disable iff (rst_i)
    take |=> !gie_r && in_svc_r)
    else $error("take left global enable set");
  AST_NO_TAKE_GIE_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    !gie_r && !retfi_i |=> !flush_o)
    else $error("taken with global enable clear");
  AST_RET_GIE: assert property (@(posedge clk_i) disable iff (rst_i)
    retfi_i |=> gie_r && pop_o && ctx_restore_o && pc_new_o == $past(stack_top_i))
    else $error("return did not restore");
  AST_SAMPLE_Q1: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(req_smp_r) |-> $past(qph_r) == 2'h0)
    else $error("request sampled outside first quarter");
  AST_TMR_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    tmr_set[1] |=> tmr_flags_r[1])
    else $error("timer_b flag not set");
  AST_TMRA_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    tmr_a_ovf_i |=> tmr_flags_r[0])
    else $error("timer_a flag not set");
  AST_CCP_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    ccp_set != 2'h0 |=> (ccp_flags_r[1:0] & $past(ccp_set)) == $past(ccp_set))
    else $error("capture flag not set");
  AST_UPPER_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    tmr_flags_r[7:2] == 6'h0 && ccp_flags_r[7:2] == 6'h0)
    else $error("unimplemented flag bits set");
  AST_PERIPHERAL_INTERRUPT_ENABLE_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
    !peripheral_interrupt_enable_r && other_flags_i == 5'h0 |-> !req_now)
    else $error("peripheral request without peripheral enable");

  //////////////////////////////////////////////////////////////////////////////
  // Further checks: return steps, reset state, holding flags and the bus
  sequence s_return;
    retfi_i;
  endsequence
  sequence s_restored;
    pop_o && ctx_restore_o && pc_load_o && !push_o;
  endsequence
  AST_RET_STEPS: assert property (@(posedge clk_i) disable iff (rst_i)
    s_return |=> s_restored)
    else $error("return steps missing");

  // Reset clears steering and flags, not only the global enable
  AST_RESET_STATE: assert property (@(posedge clk_i)
    rst_i |=> !in_svc_r && !req_smp_r && !pc_load_o && tmr_flags_r == 8'h00)
    else $error("state left set after reset");

  // Saved address and context are those of the interrupted instruction
  AST_TAKE_SAVES: assert property (@(posedge clk_i) disable iff (rst_i)
    take |=> push_pc_o == $past(pc_i) && ctx_o == $past(ctx_i))
    else $error("take saved the wrong context");

  // With global enable low outside the first quarter nothing stays latched
  AST_GIE_OFF_DROPS: assert property (@(posedge clk_i) disable iff (rst_i)
    !gie_r && qph_r != 2'h0 |=> !req_smp_r)
    else $error("request kept while global enable low");

  // A pending request is served at the first instruction boundary
  AST_PENDING_SERVED: assert property (@(posedge clk_i) disable iff (rst_i)
    req_smp_r && gie_r && instr_done_i && !retfi_i |=> pc_load_o && flush_o)
    else $error("pending request not served");

  // Flags hold until software writes them; only a write may drop one
  AST_TMR_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    tmr_flags_r[1:0] != 2'h0 && !(wr_stb && wb_adr_i == `CIC_OFF_TMR_FLAGS)
    |=> (tmr_flags_r[1:0] & $past(tmr_flags_r[1:0])) == $past(tmr_flags_r[1:0]))
    else $error("timer flag lost");
  AST_CCP_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    ccp_flags_r[1:0] != 2'h0 && !(wr_stb && wb_adr_i == `CIC_OFF_CCP_FLAGS)
    |=> (ccp_flags_r[1:0] & $past(ccp_flags_r[1:0])) == $past(ccp_flags_r[1:0]))
    else $error("capture flag lost");

  // Bus answers one cycle after the request and never twice in a row
  AST_ACK_NEXT: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged");
  AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held two cycles");

  // Status bits are sticky; only a read of the status word clears them
  AST_STAT_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_stat_r[2] && !(rd_stb && wb_adr_i == `CIC_OFF_IRQ_STAT) |=> irq_stat_r[2])
    else $error("status bit lost without a read");

  // Flush and push only ever come together with the vector load
  AST_FLUSH_WITH_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    flush_o |-> push_o && pc_load_o && !pop_o)
    else $error("flush without vector load");

  // Unused enable bits stay zero so they can never gate a phantom source
  AST_EN_UPPER_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    tmr_en_r[7:2] == 6'h0 && ccp_en_r[7:2] == 6'h0)
    else $error("unimplemented enable bits set");
endmodule : cic_core_int

/* File: tb/cic_core_model.sv */
// Purpose: Core model facing the interrupt control block: boundaries, stack and return
// Assumes: One instruction boundary every four clocks
// Notes:   One-deep return stack, enough for service without nesting
`timescale 1ns/1ns
module cic_core_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ret_req_i,
  input  wire logic        push_i,
  input  wire logic [12:0] push_pc_i,
  output logic             instr_done_o,
  output logic             retfi_o,
  output logic [12:0]      stack_top_o
);
  logic [1:0] qcnt_r;
  ////////////////////////////////////////////////////////////////////////////////
  // Instruction boundary, one clock in four like a four-phase core
  always_ff @(posedge clk_i) begin
    qcnt_r       <= rst_i ? 2'h0 : qcnt_r + 2'h1;
    instr_done_o <= !rst_i && qcnt_r == 2'h3;
  end
  // Stack keeps the pushed address; cleared so it never reads unknown
  always_ff @(posedge clk_i) begin
    if (rst_i) stack_top_o <= 13'h0000;
    else if (push_i) stack_top_o <= push_pc_i;
  end
  // Return executed only when the service software asks for it
  always_ff @(posedge clk_i) begin
    retfi_o <= !rst_i && ret_req_i;
  end
endmodule : cic_core_model

/* File: tb/core_interrupt_control_tb_top.sv */
// Purpose: Self-checking bench of the interrupt control block
// Assumes: Classic Wishbone, byte lane 0, partner core model
// Notes:   Expected results queue up; a monitor compares them as they appear
`timescale 1ns/1ns
`include "cic_defs.svh"
module core_interrupt_control_tb_top;
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic [5:0]         wb_adr_i = 6'h00;
  logic [31:0]        wb_dat_i = 32'h0;
  logic               wb_we_i = 1'b0;
  logic               wb_cyc_i = 1'b0;
  logic               wb_stb_i = 1'b0;
  logic [3:0]         wb_sel_i = 4'h0;
  logic [8:0]         evt = 9'h000;
  logic               o2o = 1'b0;
  cic_pkg::cic_mode_t cma = cic_pkg::CIC_MODE_OFF;
  logic [4:0]         oflg = 5'h00;
  logic [4:0]         oen = 5'h00;
  logic [12:0]        pc_i = 13'h0000;
  logic [7:0]         ctx_i = 8'h00;
  logic               ret_req = 1'b0;
  logic [31:0]        wb_dat_o;
  logic [12:0]        stk, push_pc_o, pc_new_o;
  logic [7:0]         ctx_o;
  logic               wb_ack_o, ido, rfi, flush_o, push_o, pop_o, pc_load_o, ctx_restore_o, irq_o;
  logic [63:0]        exp_rd[$];
  logic [15:0]        exp_pc[$];
  logic [7:0]         exp_ctx[$];
  logic [31:0]        seed = 32'h0000_7735;
  logic [31:0]        r;
  logic [31:0]        rm;
  logic               isvc;
  int                 mismatches = 0;
  int                 checked = 0;
  int                 k;
  ////////////////////////////////////////////////////////////////////////////////
  always #20 clk_i = ~clk_i;
  cic_core_int i_cic_core_int (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
    .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .tmr_a_ovf_i(evt[0]),
    .tmr_b_postscale_ovf_i(evt[1]), .tmr_b_match_i(evt[2]), .tmr_b_one_to_one_i(o2o),
    .cap_a_mode_i(cma), .cap_a_capture_i(evt[3]), .cap_a_compare_i(evt[4]),
    .cap_a_trail_i(evt[5]), .cap_b_mode_i(cma), .cap_b_capture_i(evt[6]),
    .cap_b_compare_i(evt[7]), .cap_b_trail_i(evt[8]), .other_flags_i(oflg), .other_en_i(oen),
    .pc_i, .ctx_i, .instr_done_i(ido), .retfi_i(rfi), .stack_top_i(stk), .flush_o, .push_o,
    .pop_o, .push_pc_o, .pc_load_o, .pc_new_o, .ctx_restore_o, .ctx_o, .in_service_o(isvc),
    .irq_o);
  cic_core_model i_cic_core_model (.clk_i, .rst_i, .ret_req_i(ret_req), .push_i(push_o),
    .push_pc_i(push_pc_o), .instr_done_o(ido), .retfi_o(rfi), .stack_top_o(stk));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic finish_test();
    if (mismatches == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  // Classic single cycle; a read notes its expectation and mask first
  task automatic wb(input logic [5:0] a, input logic w, input logic [7:0] d,
                    input logic [7:0] e, input logic [7:0] m);
    int n;
    n = 0;
    if (!w) exp_rd.push_back({24'h0, m, 24'h0, e & m});
    @(posedge clk_i);
    wb_adr_i <= a;
    wb_we_i  <= w;
    wb_dat_i <= {24'h0, d};
    wb_sel_i <= 4'h1;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb
  task automatic pulse(input int i);
    @(posedge clk_i);
    evt[i] <= 1'b1;
    @(posedge clk_i);
    evt <= 9'h000;
  endtask : pulse
  task automatic ret();
    @(posedge clk_i);
    ret_req <= 1'b1;
    @(posedge clk_i);
    ret_req <= 1'b0;
  endtask : ret
  // Bounded wait until every noted redirect and restore has shown up
  task automatic wait_q();
    int n;
    n = 0;
    while ((exp_pc.size() > 0 || exp_ctx.size() > 0) && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 200) mismatches++;
  endtask : wait_q
  ////////////////////////////////////////////////////////////////////////////////
  // Monitor; a redirect nobody noted compares against an impossible value
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_rd.size() > 0) begin
      rm = exp_rd[0][63:32];
      cmp(wb_dat_o & rm, exp_rd.pop_front() & 64'hFFFF_FFFF);
    end
    if (pc_load_o === 1'b1)
      cmp({16'h0, flush_o, push_o, pop_o, pc_new_o}, exp_pc.size() ? exp_pc.pop_front() : 16'hFFFF);
    if (ctx_restore_o === 1'b1) cmp({24'h0, ctx_o}, exp_ctx.size() ? exp_ctx.pop_front() : 8'hFF);
  end
  initial begin
    #(40 * 30000);
    mismatches++;
    finish_test();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(`CIC_OFF_CTRL, 1'b0, 8'h00, 8'h00, 8'hFF);
    wb(`CIC_OFF_TMR_FLAGS, 1'b0, 8'h00, 8'h00, 8'hFF);
    wb(`CIC_OFF_CCP_FLAGS, 1'b0, 8'h00, 8'h00, 8'hFF);
    wb(6'h20, 1'b1, 8'hFF, 8'h00, 8'h00);
    wb(6'h20, 1'b0, 8'h00, 8'h00, 8'hFF);
    // Only the two flag bits keep what software writes
    repeat (4) begin
      r = rnd();
      wb(r[8] ? `CIC_OFF_TMR_FLAGS : `CIC_OFF_CCP_FLAGS, 1'b1, r[7:0], 8'h00, 8'h00);
      wb(r[8] ? `CIC_OFF_TMR_FLAGS : `CIC_OFF_CCP_FLAGS, 1'b0, 8'h00, r[7:0] & 8'h03, 8'hFF);
    end
    wb(`CIC_OFF_TMR_FLAGS, 1'b1, 8'h00, 8'h00, 8'h00);
    wb(`CIC_OFF_CCP_FLAGS, 1'b1, 8'h00, 8'h00, 8'h00);
    // Each event with every enable off; last pass is a match outside 1:1
    for (int j = 0; j < 10; j++) begin
      k = (j == 9) ? 2 : j;
      o2o <= (j == 2);
      cma <= cic_pkg::cic_mode_t'(k % 3);
      pulse(k);
      r = (j == 9) ? 0 : (k == 1 || k == 2 || k >= 6) ? 2 : 1;
      wb(k < 3 ? `CIC_OFF_TMR_FLAGS : `CIC_OFF_CCP_FLAGS, 1'b0, 8'h00, r[7:0], 8'hFF);
      wb(k < 3 ? `CIC_OFF_TMR_FLAGS : `CIC_OFF_CCP_FLAGS, 1'b1, 8'h00, 8'h00, 8'h00);
    end
    // Take: peripheral enable off blocks it, then turning it on lets it through
    r = rnd();
    pc_i  <= r[12:0];
    ctx_i <= r[20:13];
    wb(`CIC_OFF_TMR_EN, 1'b1, 8'h01, 8'h00, 8'h00);
    wb(`CIC_OFF_CTRL, 1'b1, 8'h80, 8'h00, 8'h00);
    pulse(0);
    repeat (20) @(posedge clk_i);
    exp_pc.push_back({3'b110, `CIC_VECTOR});
    wb(`CIC_OFF_CTRL, 1'b1, 8'hC0, 8'h00, 8'h00);
    wait_q();
    wb(`CIC_OFF_CTRL, 1'b0, 8'h00, 8'h40, 8'hC0);
    cmp({31'h0, isvc}, 32'h1);
    // Enabled event during service only sets its flag
    wb(`CIC_OFF_CCP_EN, 1'b1, 8'h01, 8'h00, 8'h00);
    cma <= cic_pkg::CIC_MODE_CAPTURE;
    pulse(3);
    repeat (20) @(posedge clk_i);
    wb(`CIC_OFF_CCP_FLAGS, 1'b0, 8'h00, 8'h01, 8'hFF);
    // Return with flags still pending is taken again at once
    exp_pc.push_back({3'b001, r[12:0]});
    exp_pc.push_back({3'b110, `CIC_VECTOR});
    exp_ctx.push_back(r[20:13]);
    ret();
    wait_q();
    wb(`CIC_OFF_TMR_FLAGS, 1'b1, 8'h00, 8'h00, 8'h00);
    wb(`CIC_OFF_CCP_FLAGS, 1'b1, 8'h00, 8'h00, 8'h00);
    exp_pc.push_back({3'b001, r[12:0]});
    exp_ctx.push_back(r[20:13]);
    ret();
    wait_q();
    repeat (20) @(posedge clk_i);
    wb(`CIC_OFF_CTRL, 1'b0, 8'h00, 8'hC0, 8'hC0);
    // Core-group source ignores the peripheral enable
    wb(`CIC_OFF_CTRL, 1'b1, 8'h80, 8'h00, 8'h00);
    r = rnd();
    pc_i <= r[12:0];
    exp_pc.push_back({3'b110, `CIC_VECTOR});
    oen  <= 5'h01 << (r[15:13] % 5);
    oflg <= 5'h01 << (r[15:13] % 5);
    wait_q();
    oflg <= 5'h00;
    exp_pc.push_back({3'b001, r[12:0]});
    exp_ctx.push_back(ctx_i);
    ret();
    wait_q();
    // Status: masked event keeps irq low, unmasking raises it, read clears
    wb(`CIC_OFF_IRQ_STAT, 1'b0, 8'h00, 8'h00, 8'h00);
    wb(`CIC_OFF_IRQ_MASK, 1'b1, 8'h00, 8'h00, 8'h00);
    pulse(1);
    @(negedge clk_i);
    cmp({31'h0, irq_o}, 32'h0);
    wb(`CIC_OFF_IRQ_MASK, 1'b1, 8'h04, 8'h00, 8'h00);
    @(negedge clk_i);
    cmp({31'h0, irq_o}, 32'h1);
    wb(`CIC_OFF_IRQ_STAT, 1'b0, 8'h00, 8'h04, 8'h04);
    @(negedge clk_i);
    cmp({31'h0, irq_o}, 32'h0);
    // A second reset mid-run must again leave the global and peripheral enables and the timer flags clear
    wb(`CIC_OFF_CTRL, 1'b1, 8'hC0, 8'h00, 8'h00);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(`CIC_OFF_CTRL, 1'b0, 8'h00, 8'h00, 8'hFF);
    wb(`CIC_OFF_TMR_FLAGS, 1'b0, 8'h00, 8'h00, 8'hFF);
    cmp({31'h0, isvc}, 32'h0);
    finish_test();
  end
endmodule : core_interrupt_control_tb_top
